// >>> design/dds_accum.sv
// phase accumulator synthesizer advanced on an 80 MHz strobe
// assumes step is a one-cycle strobe from the same clock
module dds_accum #(
  parameter int TW_W = 32,
  parameter int OUT_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic step,
  input wire logic [TW_W-1:0] tuning_word,
  output logic [OUT_W-1:0] sample
);

  // accumulator and registered sawtooth sample
  typedef struct packed {
    logic [TW_W-1:0] phase;
    logic [OUT_W-1:0] sample;
  } dds_st_t;

  dds_st_t s_reg;
  dds_st_t s_next;

  // advance phase only on the strobe so the rate follows the reference
  always_comb begin
    s_next = s_reg;
    if (step) begin
      s_next.phase = TW_W'(s_reg.phase + tuning_word);
    end
    s_next.sample = s_reg.phase[TW_W-1 -: OUT_W];
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sample = s_reg.sample;

endmodule

// >>> design/receive_gating_and_lo_sequencer.sv
// receive gating, capture command, accept enable and offset synthesis
// assumes link_word and link_valid come from pins and need synchronising
// Operation
// - separate preamp observe gate from receiver gate
// - receiver gate may open after preamp gate
// - gating delays come from configuration words
// - no sampling clock produced; converter runs free
// - accept enable alone marks accepted data windows
// - receiver opens right after excitation, past tail
// - synthesis advances at 80 MHz, reference locked
// - only small LO offset applied here
// - sum two signals, spacing within 2.5 MHz
// - combined signal on one output, config only
// - 48-bit control words at 80 MHz rate
// - FIFO queued updates take effect together; routing is applied only by a commit while idle
// - receiver and preamp gates active low
// - capture start command active low
// - accept enable active low
module receive_gating_and_lo_sequencer #(
  parameter int FIFO_AW = 4,
  parameter int SAMP_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [rx_seq_pkg::WORD_W-1:0] link_word,
  input wire logic link_valid,
  output logic fifo_full,
  output logic seq_busy,
  output logic preamp_observe_gate_n,
  output logic preamp_gate_alias_n,
  output logic receiver_open_gate_n,
  output logic capture_start_cmd_n,
  output logic accept_enable_n,
  output logic [rx_seq_pkg::TW_W-1:0] lo_offset_word,
  output logic [SAMP_W:0] main_rf_output,
  output logic [SAMP_W:0] aux_rf_output
);

  localparam int FW = rx_seq_pkg::FIELD_W;
  localparam int TW = rx_seq_pkg::TW_W;
  localparam logic [FIFO_AW:0] DEPTH = (FIFO_AW+1)'(2**FIFO_AW);

  // whole module state
  typedef struct packed {
    logic [rx_seq_pkg::WORD_W-1:0] word_s1;   // first sync stage
    logic [rx_seq_pkg::WORD_W-1:0] word_s2;   // second sync stage
    logic valid_s1;
    logic valid_s2;
    logic [2:0] tick_acc;                     // fractional rate accumulator
    logic tick;                               // 80 MHz strobe
    logic [FIFO_AW:0] wr_ptr;
    logic [FIFO_AW:0] rd_ptr;
    logic rd_pend;                            // read data arrives next cycle
    logic full;
    logic [FW-1:0] sh_pre;                    // pending values
    logic [FW-1:0] sh_rx;
    logic [FW-1:0] sh_adc;
    logic [FW-1:0] sh_len;
    logic [TW-1:0] sh_lo;
    logic [TW-1:0] sh_fa;
    logic [TW-1:0] sh_fb;
    logic [1:0] sh_route;
    logic [FW-1:0] act_pre;                   // values in force
    logic [FW-1:0] act_rx;
    logic [FW-1:0] act_adc;
    logic [FW-1:0] act_len;
    logic [TW-1:0] act_lo;
    logic [TW-1:0] act_fa;
    logic [TW-1:0] act_fb;
    logic [1:0] act_route;
    rx_seq_pkg::seq_t seq;
    logic [FW:0] cnt;                         // ticks since excitation end
    logic pre_n;
    logic rx_n;
    logic cap_n;
    logic acc_n;
    logic [SAMP_W:0] main_out;
    logic [SAMP_W:0] aux_out;
  } st_t;

  st_t s_reg;
  st_t s_next;

  // helpers read by the assertions as well
  logic [rx_seq_pkg::WORD_W-1:0] rd_data;
  logic push;
  logic pop;
  logic commit_now;
  logic [FIFO_AW:0] fill;
  logic [FW-1:0] rx_eff;
  logic [FW-1:0] adc_eff;
  logic [FW:0] end_cnt;
  logic [TW-1:0] fb_eff;
  logic [SAMP_W-1:0] samp_a;
  logic [SAMP_W-1:0] samp_b;

  // larger of two delays
  function automatic logic [FW-1:0] max_dly(input logic [FW-1:0] a, input logic [FW-1:0] b);
    max_dly = (a > b) ? a : b;
  endfunction

  // keep tone b within the combiner spacing of tone a
  function automatic logic [TW-1:0] clamp_b(input logic [TW-1:0] fa, input logic [TW-1:0] fb);
    logic signed [TW-1:0] diff;
    diff = signed'(TW'(fb - fa));
    if (diff > signed'(rx_seq_pkg::COMB_DIFF_TW)) begin
      clamp_b = TW'(fa + rx_seq_pkg::COMB_DIFF_TW);
    end else if (diff < -signed'(rx_seq_pkg::COMB_DIFF_TW)) begin
      clamp_b = TW'(fa - rx_seq_pkg::COMB_DIFF_TW);
    end else begin
      clamp_b = fb;
    end
  endfunction

  // sign-extend a sawtooth sample to the output width
  function automatic logic [SAMP_W:0] sext(input logic [SAMP_W-1:0] v);
    sext = {v[SAMP_W-1], v};
  endfunction

  // order the delays so the receiver never opens before the preamp,
  // and capture never starts before the receiver is open
  assign rx_eff = max_dly(s_reg.act_rx, s_reg.act_pre);
  assign adc_eff = max_dly(s_reg.act_adc, rx_eff);
  assign end_cnt = (FW+1)'({1'b0, adc_eff} + {1'b0, s_reg.act_len});
  assign fb_eff = clamp_b(s_reg.act_fa, s_reg.act_fb);
  assign fill = (FIFO_AW+1)'(s_reg.wr_ptr - s_reg.rd_ptr);
  // one word taken per 80 MHz strobe, dropped when the queue is full
  assign push = s_reg.tick && s_reg.valid_s2 && (fill != DEPTH);
  assign pop = (fill != '0) && !s_reg.rd_pend;
  assign commit_now = s_reg.rd_pend && (rd_data[rx_seq_pkg::OP_POS +: rx_seq_pkg::OP_W] == rx_seq_pkg::OP_COMMIT);

  // queued control words; read data are registered inside
  word_fifo_mem #(
    .DATA_W(rx_seq_pkg::WORD_W),
    .ADDR_W(FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(push),
    .wr_addr(s_reg.wr_ptr[FIFO_AW-1:0]),
    .wr_data(s_reg.word_s2),
    .rd_en(pop),
    .rd_addr(s_reg.rd_ptr[FIFO_AW-1:0]),
    .rd_data(rd_data)
  );

  // two tones for the combiner, b held within the spacing of a, stepped at 80 MHz
  dds_accum #(
    .TW_W(TW),
    .OUT_W(SAMP_W)
  ) u_dds_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .step(s_reg.tick),
    .tuning_word(s_reg.act_fa),
    .sample(samp_a)
  );

  dds_accum #(
    .TW_W(TW),
    .OUT_W(SAMP_W)
  ) u_dds_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .step(s_reg.tick),
    .tuning_word(fb_eff),
    .sample(samp_b)
  );

  // next state of the whole block
  always_comb begin
    logic [2:0] acc_sum;
    logic [FW-1:0] fld;
    logic [TW-1:0] tw;
    logic [rx_seq_pkg::OP_W-1:0] op;
    logic [SAMP_W:0] mix;
    acc_sum = '0;
    fld = '0;
    tw = '0;
    op = '0;
    mix = '0;
    s_next = s_reg;
    // pin inputs pass two flops; only the second stage is used
    s_next.word_s1 = link_word;
    s_next.word_s2 = s_reg.word_s1;
    s_next.valid_s1 = link_valid;
    s_next.valid_s2 = s_reg.valid_s1;
    // 80 MHz strobe from the 200 MHz clock: two ticks every five clocks
    acc_sum = 3'(s_reg.tick_acc + rx_seq_pkg::TICK_INC);
    s_next.tick = (acc_sum >= rx_seq_pkg::TICK_MOD);
    s_next.tick_acc = s_next.tick ? 3'(acc_sum - rx_seq_pkg::TICK_MOD) : acc_sum;
    // queue pointers
    if (push) begin
      s_next.wr_ptr = (FIFO_AW+1)'(s_reg.wr_ptr + 1'b1);
    end
    if (pop) begin
      s_next.rd_ptr = (FIFO_AW+1)'(s_reg.rd_ptr + 1'b1);
    end
    s_next.rd_pend = pop;
    s_next.full = ((FIFO_AW+1)'(s_next.wr_ptr - s_next.rd_ptr) == DEPTH);
    // receive sequence, advanced only on the strobe so edges align to words
    if (s_reg.tick && (s_reg.seq == rx_seq_pkg::SEQ_RUN)) begin
      if (s_reg.cnt >= end_cnt) begin
        s_next.seq = rx_seq_pkg::SEQ_IDLE;
        s_next.pre_n = 1'b1;
        s_next.rx_n = 1'b1;
        s_next.cap_n = 1'b1;
        s_next.acc_n = 1'b1;
      end else begin
        s_next.cnt = (FW+1)'(s_reg.cnt + 1'b1);
        // low opens: preamp first, receiver no earlier
        s_next.pre_n = !(s_reg.cnt >= {1'b0, s_reg.act_pre});
        s_next.rx_n = !(s_reg.cnt >= {1'b0, rx_eff});
        s_next.cap_n = !(s_reg.cnt >= {1'b0, adc_eff});
        // accept window alone decides what the receive unit takes in
        s_next.acc_n = !((s_reg.cnt >= {1'b0, adc_eff}) && (s_reg.cnt < end_cnt));
      end
    end
    // decode at most one queued word every two clocks
    if (s_reg.rd_pend) begin
      op = rd_data[rx_seq_pkg::OP_POS +: rx_seq_pkg::OP_W];
      fld = rd_data[FW-1:0];
      tw = rd_data[TW-1:0];
      unique case (op)
        rx_seq_pkg::OP_PREAMP_DLY: s_next.sh_pre = fld;
        rx_seq_pkg::OP_RX_DLY: s_next.sh_rx = fld;
        rx_seq_pkg::OP_ADC_DLY: s_next.sh_adc = fld;
        rx_seq_pkg::OP_ACQ_LEN: s_next.sh_len = fld;
        rx_seq_pkg::OP_LO_OFS: s_next.sh_lo = tw;
        rx_seq_pkg::OP_FREQ_A: s_next.sh_fa = tw;
        rx_seq_pkg::OP_FREQ_B: s_next.sh_fb = tw;
        rx_seq_pkg::OP_ROUTE: s_next.sh_route = rd_data[1:0];
        rx_seq_pkg::OP_COMMIT: begin
          // all pending delays, offset and tones land in one cycle, however many were sent
          s_next.act_pre = s_reg.sh_pre;
          s_next.act_rx = s_reg.sh_rx;
          s_next.act_adc = s_reg.sh_adc;
          s_next.act_len = s_reg.sh_len;
          s_next.act_lo = s_reg.sh_lo;
          s_next.act_fa = s_reg.sh_fa;
          s_next.act_fb = s_reg.sh_fb;
          // output routing is a setup step, never switched mid-sequence
          if (s_reg.seq == rx_seq_pkg::SEQ_IDLE) begin
            s_next.act_route = s_reg.sh_route;
          end
        end
        rx_seq_pkg::OP_START: begin
          // excitation has ended; restart the gating count
          if (s_reg.seq == rx_seq_pkg::SEQ_IDLE) begin
            s_next.seq = rx_seq_pkg::SEQ_RUN;
            s_next.cnt = '0;
          end
        end
        rx_seq_pkg::OP_ABORT: begin
          s_next.seq = rx_seq_pkg::SEQ_IDLE;
          s_next.pre_n = 1'b1;
          s_next.rx_n = 1'b1;
          s_next.cap_n = 1'b1;
          s_next.acc_n = 1'b1;
        end
        default: begin
          // no-op and unused codes are ignored
        end
      endcase
    end
    // combiner: tone a alone, or a plus b, to exactly one output
    mix = s_reg.act_route[rx_seq_pkg::ROUTE_COMB_POS] ?
          (SAMP_W+1)'(sext(samp_a) + sext(samp_b)) : sext(samp_a);
    if (s_reg.act_route[rx_seq_pkg::ROUTE_SEL_POS]) begin
      s_next.main_out = '0;
      s_next.aux_out = mix;
    end else begin
      s_next.main_out = mix;
      s_next.aux_out = '0;
    end
  end

  // state register with reset values
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.sh_pre <= rx_seq_pkg::RST_PREAMP_DLY;
      s_reg.sh_rx <= rx_seq_pkg::RST_RX_DLY;
      s_reg.sh_adc <= rx_seq_pkg::RST_ADC_DLY;
      s_reg.sh_len <= rx_seq_pkg::RST_ACQ_LEN;
      s_reg.act_pre <= rx_seq_pkg::RST_PREAMP_DLY;
      s_reg.act_rx <= rx_seq_pkg::RST_RX_DLY;
      s_reg.act_adc <= rx_seq_pkg::RST_ADC_DLY;
      s_reg.act_len <= rx_seq_pkg::RST_ACQ_LEN;
      s_reg.sh_lo <= rx_seq_pkg::RST_TW;
      s_reg.act_lo <= rx_seq_pkg::RST_TW;
      s_reg.sh_route <= rx_seq_pkg::RST_ROUTE;
      s_reg.act_route <= rx_seq_pkg::RST_ROUTE;
      s_reg.seq <= rx_seq_pkg::SEQ_IDLE;
      s_reg.pre_n <= 1'b1;
      s_reg.rx_n <= 1'b1;
      s_reg.cap_n <= 1'b1;
      s_reg.acc_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register; no sampling clock is made,
  // the converter keeps its own free-running 20 MHz
  assign fifo_full = s_reg.full;
  assign seq_busy = (s_reg.seq == rx_seq_pkg::SEQ_RUN);
  assign preamp_observe_gate_n = s_reg.pre_n;
  assign preamp_gate_alias_n = s_reg.pre_n;
  assign receiver_open_gate_n = s_reg.rx_n;
  assign capture_start_cmd_n = s_reg.cap_n;
  assign accept_enable_n = s_reg.acc_n;
  // only the small offset; the fixed intermediate shift lives downstream
  assign lo_offset_word = s_reg.act_lo;
  assign main_rf_output = s_reg.main_out;
  assign aux_rf_output = s_reg.aux_out;

  // checks on the gating order, timing and queue
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_rx_after_preamp: assert property (!receiver_open_gate_n |-> !preamp_observe_gate_n)
    else $error("receiver open while preamp closed");
  chk_capture_after_rx: assert property (!capture_start_cmd_n |-> !receiver_open_gate_n)
    else $error("capture started with receiver closed");
  chk_accept_in_capture: assert property (!accept_enable_n |-> !capture_start_cmd_n && seq_busy)
    else $error("accept window outside capture");
  chk_gate_on_tick: assert property ($changed(receiver_open_gate_n) || $changed(preamp_observe_gate_n)
    |-> $past(s_reg.tick) || $past(s_reg.rd_pend))
    else $error("gate moved off the strobe");
  // gaps alternate two and three clocks: a short gap is always followed by a long one
  chk_tick_spacing: assert property (s_reg.tick |=> !s_reg.tick ##1 (!s_reg.tick or (s_reg.tick ##1 !s_reg.tick [*2])))
    else $error("strobe faster than 80 MHz");
  // the first strobe after reset comes three clocks late, so skip that window
  chk_tick_present: assert property ((!$past(rst) && !s_reg.tick) ##1 !s_reg.tick |=> s_reg.tick)
    else $error("strobe slower than 80 MHz");
  chk_commit_atomic: assert property (commit_now |=> s_reg.act_pre == $past(s_reg.sh_pre)
    && s_reg.act_rx == $past(s_reg.sh_rx) && s_reg.act_fa == $past(s_reg.sh_fa))
    else $error("commit did not land together");
  chk_route_idle: assert property ($changed(s_reg.act_route) |-> $past(s_reg.seq) == rx_seq_pkg::SEQ_IDLE)
    else $error("route changed during sequence");
  chk_diff_limit: assert property (TW'(fb_eff - s_reg.act_fa) <= rx_seq_pkg::COMB_DIFF_TW
    || TW'(s_reg.act_fa - fb_eff) <= rx_seq_pkg::COMB_DIFF_TW)
    else $error("tone spacing beyond limit");
  chk_one_output: assert property (main_rf_output == '0 || aux_rf_output == '0)
    else $error("mix on both outputs");
  chk_queue_bound: assert property (fill <= DEPTH && (fill == DEPTH) == s_reg.full)
    else $error("queue count out of range");
  chk_idle_closed: assert property (!seq_busy && $past(!seq_busy) |-> receiver_open_gate_n
    && capture_start_cmd_n && accept_enable_n)
    else $error("gate open while idle");

  cov_sequence_start: cover property (!seq_busy ##1 seq_busy);
  cov_accept_open: cover property (accept_enable_n ##1 !accept_enable_n);
  cov_commit: cover property (commit_now);
  cov_queue_full: cover property (fifo_full);

endmodule

// >>> design/rx_seq_pkg.sv
// constants shared by the receive gating sequencer and its helpers
// assumes a single 200 MHz ref_clk domain and a synchronous active-high reset
package rx_seq_pkg;

  // control word layout on the parallel link
  localparam int WORD_W = 48;
  localparam int OP_W = 4;
  localparam int OP_POS = 44;
  localparam int FIELD_W = 16;
  localparam int TW_W = 32;

  // opcodes carried in the top nibble of a control word
  localparam logic [OP_W-1:0] OP_NOP = 4'h0;
  localparam logic [OP_W-1:0] OP_PREAMP_DLY = 4'h1;
  localparam logic [OP_W-1:0] OP_RX_DLY = 4'h2;
  localparam logic [OP_W-1:0] OP_ADC_DLY = 4'h3;
  localparam logic [OP_W-1:0] OP_ACQ_LEN = 4'h4;
  localparam logic [OP_W-1:0] OP_LO_OFS = 4'h5;
  localparam logic [OP_W-1:0] OP_FREQ_A = 4'h6;
  localparam logic [OP_W-1:0] OP_FREQ_B = 4'h7;
  localparam logic [OP_W-1:0] OP_ROUTE = 4'h8;
  localparam logic [OP_W-1:0] OP_COMMIT = 4'h9;
  localparam logic [OP_W-1:0] OP_START = 4'hA;
  localparam logic [OP_W-1:0] OP_ABORT = 4'hB;

  // route field positions inside an OP_ROUTE payload
  localparam int ROUTE_SEL_POS = 0;
  localparam int ROUTE_COMB_POS = 1;

  // clock rates in MHz; the 80 MHz word and synthesis rate is 4 x 20 MHz
  localparam int REF_CLK_MHZ = 200;
  localparam int REF_IN_MHZ = 20;
  localparam int REF_MULT = 4;
  localparam int DDS_CLK_MHZ = REF_IN_MHZ * REF_MULT;
  localparam int RATE_GCD_MHZ = 40;
  // fractional strobe: TICK_INC ticks every TICK_MOD clocks gives 80 MHz
  localparam logic [2:0] TICK_INC = 3'(DDS_CLK_MHZ / RATE_GCD_MHZ);
  localparam logic [2:0] TICK_MOD = 3'(REF_CLK_MHZ / RATE_GCD_MHZ);

  // combiner spacing limit, in kHz, and the matching tuning word
  localparam longint COMB_DIFF_KHZ = 2500;
  localparam longint KHZ_PER_MHZ = 1000;
  localparam logic [TW_W-1:0] COMB_DIFF_TW =
    TW_W'((COMB_DIFF_KHZ << TW_W) / (longint'(DDS_CLK_MHZ) * KHZ_PER_MHZ));

  // values after reset; delays and length in 80 MHz ticks
  localparam logic [FIELD_W-1:0] RST_PREAMP_DLY = 16'h0002;
  localparam logic [FIELD_W-1:0] RST_RX_DLY = 16'h0004;
  localparam logic [FIELD_W-1:0] RST_ADC_DLY = 16'h0006;
  localparam logic [FIELD_W-1:0] RST_ACQ_LEN = 16'h0100;
  localparam logic [TW_W-1:0] RST_TW = 32'h0000_0000;
  localparam logic [1:0] RST_ROUTE = 2'h0;

  // receive sequencer states
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } seq_t;

endpackage

// >>> design/word_fifo_mem.sv
// small dual-port memory holding queued control words
// assumes one clock; the caller owns pointers, full and empty
module word_fifo_mem #(
  parameter int DATA_W = 48,
  parameter int ADDR_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  // storage array; no reset, contents are never read before written
  logic [DATA_W-1:0] mem_reg [2**ADDR_W];

  // state of the read side
  typedef struct packed {
    logic [DATA_W-1:0] rd_data;
  } mem_st_t;

  mem_st_t s_reg;
  mem_st_t s_next;

  // next read register value
  always_comb begin
    s_next = s_reg;
    if (rd_en) begin
      s_next.rd_data = mem_reg[rd_addr];
    end
  end

  // registered read port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // write port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  assign rd_data = s_reg.rd_data;

endmodule

// >>> verif/link_ctrl_model.sv
// link controller model: presents control words on the parallel link
// assumes ref_clk comes from the bench and the far end syncs both lines
module link_ctrl_model (
  input wire logic ref_clk,
  output logic [rx_seq_pkg::WORD_W-1:0] link_word,
  output logic link_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle link from time zero
  initial begin
    link_word = '0;
    link_valid = 1'b0;
  end

  // one word held three clocks, then two idle clocks; five clocks carry
  // two ticks, so each word meets at least one tick, and a second take
  // of the same word is harmless for every opcode used here
  task automatic send(input logic [rx_seq_pkg::WORD_W-1:0] w);
    @(posedge ref_clk);
    link_word <= w;
    link_valid <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // released lines show the inverse, so stale data is never trusted
    link_word <= ~w;
    link_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule

// >>> verif/test_receive_gating_and_lo_sequencer.sv
// self-checking bench for the receive gating and offset sequencer
// assumes the link model drives the link; gate timing is in 80 MHz ticks
module test_receive_gating_and_lo_sequencer;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0; // 200 MHz
  logic rst = 1'b1; // held for the first 16 clocks
  logic [rx_seq_pkg::WORD_W-1:0] link_word;
  logic link_valid;
  logic fifo_full, seq_busy, preamp_observe_gate_n, preamp_gate_alias_n;
  logic receiver_open_gate_n, capture_start_cmd_n, accept_enable_n;
  logic [rx_seq_pkg::TW_W-1:0] lo_offset_word;
  logic [12:0] main_rf_output, aux_rf_output;
  int n_mismatch = 0;
  int n_checks = 0;
  int t_pre, t_rx, t_cap, t_acc, n_acc; // clock counts of one sequence

  always #2.5 ref_clk = ~ref_clk;

  link_ctrl_model u_link_ctrl_model (.ref_clk(ref_clk), .link_word(link_word), .link_valid(link_valid));

  receive_gating_and_lo_sequencer u_receive_gating_and_lo_sequencer (
    .ref_clk(ref_clk), .rst(rst), .link_word(link_word), .link_valid(link_valid),
    .fifo_full(fifo_full), .seq_busy(seq_busy), .preamp_observe_gate_n(preamp_observe_gate_n),
    .preamp_gate_alias_n(preamp_gate_alias_n), .receiver_open_gate_n(receiver_open_gate_n),
    .capture_start_cmd_n(capture_start_cmd_n), .accept_enable_n(accept_enable_n),
    .lo_offset_word(lo_offset_word), .main_rf_output(main_rf_output), .aux_rf_output(aux_rf_output)
  );

  // idle status: five gates closed (high), not full, not busy = 0x7C
  function automatic logic [31:0] st();
    return 32'({preamp_observe_gate_n, preamp_gate_alias_n, receiver_open_gate_n,
                capture_start_cmd_n, accept_enable_n, fifo_full, seq_busy});
  endfunction

  // compare of design values, four-state safe
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare of a bench-measured clock count against a window
  task automatic chk_cnt(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  task automatic put(input logic [rx_seq_pkg::OP_W-1:0] op, input logic [43:0] pl);
    u_link_ctrl_model.send({op, pl});
  endtask

  // record the clock on which each gate opens and how long accept stays low
  task automatic meas();
    t_pre = -1;
    t_rx = -1;
    t_cap = -1;
    t_acc = -1;
    n_acc = 0;
    for (int c = 0; c < 3000; c++) begin
      @(posedge ref_clk);
      #1;
      if (t_pre < 0 && preamp_observe_gate_n === 1'b0) t_pre = c;
      if (t_rx < 0 && receiver_open_gate_n === 1'b0) t_rx = c;
      if (t_cap < 0 && capture_start_cmd_n === 1'b0) t_cap = c;
      if (t_acc < 0 && accept_enable_n === 1'b0) t_acc = c;
      if (accept_enable_n === 1'b0) n_acc++;
      chk_word(32'(preamp_gate_alias_n), 32'(preamp_observe_gate_n));
      // receiver keeps nothing until capture start is low
      if (accept_enable_n === 1'b0) chk_word(32'(capture_start_cmd_n), 32'h0000_0000);
      if (t_acc >= 0 && seq_busy === 1'b0) break;
    end
    chk_word(st(), 32'h0000_007C);
  endtask

  // start runs in parallel with the measurement, gates may open early
  task automatic run_seq();
    fork
      put(rx_seq_pkg::OP_START, 44'h0);
      meas();
    join
  endtask

  task automatic t_reset();
    chk_word(st(), 32'h0000_007C);
    chk_word(lo_offset_word, 32'h0000_0000);
    chk_word(32'({main_rf_output, aux_rf_output}), 32'h0000_0000);
    $display("done: reset");
  endtask

  // defaults 2/4/6 ticks and 256 accepted ticks = 640 clocks
  task automatic t_default();
    run_seq();
    chk_cnt(t_pre, 1, 100);
    chk_cnt(t_rx - t_pre, 4, 5);
    chk_cnt(t_cap - t_rx, 4, 5);
    chk_cnt(t_acc - t_cap, 0, 0);
    chk_cnt(n_acc, 640, 640);
    $display("done: default");
  endtask

  // receiver delay below preamp delay is raised to it; nine ticks to capture
  task automatic t_order();
    put(rx_seq_pkg::OP_PREAMP_DLY, 44'h0003);
    put(rx_seq_pkg::OP_RX_DLY, 44'h0001);
    put(rx_seq_pkg::OP_ADC_DLY, 44'h000C);
    put(rx_seq_pkg::OP_ACQ_LEN, 44'h0008);
    put(rx_seq_pkg::OP_COMMIT, 44'h0);
    run_seq();
    chk_cnt(t_rx - t_pre, 0, 0);
    chk_cnt(t_cap - t_rx, 22, 23);
    chk_cnt(t_acc - t_cap, 0, 0);
    chk_cnt(n_acc, 20, 20);
    $display("done: order");
  endtask

  // abort while accepting closes every gate at once
  task automatic t_abort();
    put(rx_seq_pkg::OP_ACQ_LEN, 44'h0100);
    put(rx_seq_pkg::OP_COMMIT, 44'h0);
    put(rx_seq_pkg::OP_START, 44'h0);
    for (int c = 0; c < 200 && accept_enable_n !== 1'b0; c++) begin
      @(posedge ref_clk);
      #1;
    end
    chk_word(32'(accept_enable_n), 32'h0000_0000);
    put(rx_seq_pkg::OP_ABORT, 44'h0);
    repeat (8) @(posedge ref_clk);
    #1;
    chk_word(st(), 32'h0000_007C);
    $display("done: abort");
  endtask

  // offset stays pending until commit
  task automatic t_lo();
    put(rx_seq_pkg::OP_LO_OFS, 44'h0001_2345);
    repeat (12) @(posedge ref_clk);
    #1;
    chk_word(lo_offset_word, 32'h0000_0000);
    put(rx_seq_pkg::OP_COMMIT, 44'h0);
    repeat (12) @(posedge ref_clk);
    #1;
    chk_word(lo_offset_word, 32'h0001_2345);
    $display("done: offset");
  endtask

  // 500 clocks = 200 ticks; step 2^24 moves the top 12 phase bits by 0xC80
  task automatic t_dds();
    logic [11:0] s1;
    logic [11:0] s2;
    put(rx_seq_pkg::OP_FREQ_A, 44'h0100_0000);
    put(rx_seq_pkg::OP_COMMIT, 44'h0);
    repeat (10) @(posedge ref_clk);
    #1;
    s1 = main_rf_output[11:0];
    repeat (500) @(posedge ref_clk);
    #1;
    s2 = main_rf_output[11:0];
    chk_word(32'(12'(s2 - s1)), 32'h0000_0C80);
    chk_word(32'(aux_rf_output), 32'h0000_0000);
    put(rx_seq_pkg::OP_ROUTE, 44'h0001);
    put(rx_seq_pkg::OP_COMMIT, 44'h0);
    repeat (10) @(posedge ref_clk);
    #1;
    s1 = aux_rf_output[11:0];
    repeat (500) @(posedge ref_clk);
    #1;
    s2 = aux_rf_output[11:0];
    chk_word(32'(12'(s2 - s1)), 32'h0000_0C80);
    chk_word(32'(main_rf_output), 32'h0000_0000);
    // b asked at 2^28, held to a plus 2.5 MHz (2^27): sum moves 0xC80 + 0x080
    put(rx_seq_pkg::OP_FREQ_B, 44'h1000_0000);
    put(rx_seq_pkg::OP_ROUTE, 44'h0003);
    put(rx_seq_pkg::OP_COMMIT, 44'h0);
    repeat (10) @(posedge ref_clk);
    #1;
    s1 = aux_rf_output[11:0];
    repeat (500) @(posedge ref_clk);
    #1;
    s2 = aux_rf_output[11:0];
    chk_word(32'(12'(s2 - s1)), 32'h0000_0D00);
    chk_word(32'(main_rf_output), 32'h0000_0000);
    $display("done: synthesis and route");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_default();
    t_order();
    t_abort();
    t_lo();
    t_dds();
    give_verdict();
  end

  // watchdog: the whole run needs a few thousand clocks
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
